// *** dv/setw_mst.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// two-wire bus master model
// ****
module setw_mst #(
  parameter int U = 250
) (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // start, also repeated start
  task automatic start();
    pull = 1'b0;
    #(2 * U);
    scl = 1'b1;
    #U;
    pull = 1'b1;
    #U;
    scl = 1'b0;
    #U;
  endtask : start
  // stop, then bus free
  task automatic stop();
    pull = 1'b1;
    #U;
    scl = 1'b1;
    #U;
    pull = 1'b0;
    #(4 * U);
  endtask : stop
  // nine bits msb first, 1 releases
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      pull = !tx[i];
      #U;
      scl = 1'b1;
      #U;
      rx[i] = sda;
      #U;
      scl = 1'b0;
      #U;
    end
  endtask : xfer
endmodule : setw_mst
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// memory slave bench
// ****
module testbench;
  import setw_pkg::*;
  localparam int WC = 2000;
  localparam logic [7:0] SW = {DEV_TYPE_DEFAULT, 2'b10, 1'b1, 1'b0};
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } setw_row_s;
  setw_row_s rows [9] = '{
    '{1'b0, ADDR_STATUS, 32'h0, 32'h1 << STAT_READY_BIT, 1'b0},
    '{1'b1, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_CTRL, 32'h1, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h1 << CTRL_EN_BIT, 1'b0},
    '{1'b1, ADDR_STATUS, 32'hff, 32'h0, 1'b0},
    '{1'b0, ADDR_STATUS, 32'h0, 32'h1 << STAT_READY_BIT, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'hffc, 32'h5, 32'h0, 1'b1}};
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic sda_out, sda_oe, busy, scl, pull, er, ack;
  setw_line_s line_in;
  logic [1:0] device_select_inputs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] rr;
  logic [7:0] pg [16];
  int err_total, check_count, blen, n;
  wire logic sda_w;
  assign sda_w = !(sda_oe | pull);
  setw_slave #(
    .WC_CYCLES(WC),
    .DEV_TYPE(DEV_TYPE_DEFAULT)
  ) i_dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .line_in(line_in),
    .device_select_inputs(device_select_inputs),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .busy(busy),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );
  setw_mst i_mst (
    .scl(scl),
    .pull(pull),
    .sda(sda_w)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk) line_in <= {scl, sda_w};
  always @(posedge sys_clk) if (busy === 1'b1) blen <= blen + 1;
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("BAD pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic sb(input logic [7:0] b);
    i_mst.xfer({b, 1'b1}, rr);
    ack = !rr[0];
  endtask : sb
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #700000;
    err_total++;
    $display("BAD watchdog expected end seen timeout");
    summarize();
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    line_in = 2'b11;
    device_select_inputs = 2'b10;
    err_total = 0;
    check_count = 0;
    blen = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("sda_oe", 32'h0, 32'(sda_oe));
    chk("busy", 32'h0, 32'(busy));
    chk("sda_out", 32'h0, 32'(sda_out));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status early", 32'h0, rd);
    $display("test reset done");
    repeat (300) @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", 32'(rows[i].e), 32'(er));
      if (!rows[i].w) chk("prdata", rows[i].x, rd);
    end
    $display("test registers done");
    i_mst.start();
    sb({DEV_TYPE_DEFAULT, 2'b01, 2'b10});
    chk("ack other select", 32'h0, 32'(ack));
    i_mst.stop();
    apb(1'b1, ADDR_CTRL, 32'h0);
    i_mst.start();
    sb(SW);
    chk("ack disabled", 32'h0, 32'(ack));
    i_mst.stop();
    apb(1'b1, ADDR_CTRL, 32'h1);
    $display("test refuse done");
    i_mst.start();
    sb(SW);
    chk("ack slave", 32'h1, 32'(ack));
    sb(8'h2e);
    chk("ack word", 32'h1, 32'(ack));
    for (int j = 0; j < 17; j++) begin
      sb(8'h40 + 8'(j));
      chk("ack data", 32'h1, 32'(ack));
      pg[(14 + j) % 16] = 8'h40 + 8'(j);
    end
    i_mst.stop();
    chk("busy after stop", 32'h1, 32'(busy));
    i_mst.start();
    sb(SW);
    chk("ack while busy", 32'h0, 32'(ack));
    chk("sda_oe busy", 32'h0, 32'(sda_oe));
    i_mst.stop();
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("busy end", 32'h0, 32'(busy));
    chk("busy length", 32'(WC), 32'(blen));
    i_mst.start();
    sb(SW);
    chk("poll ack", 32'h1, 32'(ack));
    sb(8'h20);
    i_mst.start();
    sb(SW | 8'h01);
    chk("ack read", 32'h1, 32'(ack));
    for (int k = 0; k < 16; k++) begin
      i_mst.xfer({8'hff, k == 15}, rr);
      chk("read byte", 32'(pg[k]), 32'(rr[8:1]));
    end
    i_mst.stop();
    $display("test page done");
    summarize();
  end
endmodule : testbench
`default_nettype wire

// *** hw/setw_pkg.sv ***
// ************************************
// constants for the two-wire memory slave
// ************************************
package setw_pkg;

  localparam int SYS_CLK_PERIOD_PS = 8000;
  localparam int GLITCH_FILTER_CONSTANT_NS = 100;
  localparam int FILT_CYC = (GLITCH_FILTER_CONSTANT_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int WRITE_CYCLE_TIME_MS = 10;
  localparam int WC_CYC = WRITE_CYCLE_TIME_MS * 1000000 / (SYS_CLK_PERIOD_PS / 1000);
  localparam int POWERUP_DELAY_NS = 2000;
  localparam int PUP_CYC = POWERUP_DELAY_NS * 1000 / SYS_CLK_PERIOD_PS;

  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 16;
  // arbitrary device type code
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;

  localparam int LN_SCL = 1;
  localparam int LN_SDA = 0;

  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_STATE_LSB = 4;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;

  typedef enum {
    ST_IDLE, ST_SLAVE, ST_SACK, ST_WORD, ST_WACK,
    ST_WDATA, ST_DACK, ST_RDATA, ST_RACK
  } setw_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } setw_line_s;

endpackage : setw_pkg

// *** hw/setw_slave.sv ***
`timescale 1ns/100ps
`default_nettype none

module setw_slave #(
  parameter int WC_CYCLES = setw_pkg::WC_CYC,
  parameter logic [3:0] DEV_TYPE = setw_pkg::DEV_TYPE_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire setw_pkg::setw_line_s line_in,
  input wire logic [1:0] device_select_inputs,
  output logic sda_out,
  output logic sda_oe,
  output logic busy,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import setw_pkg::*;

  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int WCW = $clog2(WC_CYCLES + 1);
  localparam int PW = $clog2(PUP_CYC + 1);

  if (WC_CYCLES < 2) begin : g_bad_wc
    $error("write cycle count must be at least two");
  end

  logic [1:0] ln_m, ln_s, ln_f, ln_p;
  logic [1:0] sel_m, sel_s;
  logic scl, sda, scl_p, sda_p;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [PW-1:0] pup_cnt;
  logic ready, ctrl_en, live;
  setw_state_e state;
  logic [2:0] bitcnt;
  logic [7:0] shreg, rx_byte, rd_byte;
  logic [8:0] addr;
  logic [4:0] page;
  logic rw, ack_drv;
  logic [PAGE_BYTES-1:0] pmask;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [MEM_BYTES];
  logic [WCW-1:0] wc_cnt;
  logic wc_start, commit;

  // ************************************
  // line synchronisers and glitch filters
  // ************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ln_m <= '1;
      ln_s <= '1;
      sel_m <= '0;
      sel_s <= '0;
    end else begin
      ln_m <= line_in;
      ln_s <= ln_m;
      sel_m <= device_select_inputs;
      sel_s <= sel_m;
    end
  end

  for (genvar gi = 0; gi < 2; gi++) begin : g_filt
    logic [FW-1:0] cnt;
    logic flt;
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        cnt <= '0;
        flt <= 1'b1;
      end else if (ln_s[gi] == flt) begin
        cnt <= '0;
      end else if (cnt == FW'(FILT_CYC - 1)) begin
        cnt <= '0;
        flt <= ln_s[gi];
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
    assign ln_f[gi] = flt;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ln_p <= '1;
    end else begin
      ln_p <= ln_f;
    end
  end

  assign scl = ln_f[LN_SCL];
  assign sda = ln_f[LN_SDA];
  assign scl_p = ln_p[LN_SCL];
  assign sda_p = ln_p[LN_SDA];
  assign scl_rise = scl & ~scl_p;
  assign scl_fall = ~scl & scl_p;
  assign start_c = scl & scl_p & sda_p & ~sda;
  assign stop_c = scl & scl_p & ~sda_p & sda;

  // ************************************
  // power-up hold-off
  // ************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pup_cnt <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      pup_cnt <= pup_cnt + 1'b1;
      ready <= (pup_cnt == PW'(PUP_CYC - 1));
    end
  end

  assign live = ready & ctrl_en & ~busy;

  // ************************************
  // protocol engine
  // ************************************
  assign rx_byte = {shreg[6:0], sda};
  assign rd_byte = mem[addr];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      addr <= '0;
      page <= '0;
      rw <= 1'b0;
      ack_drv <= 1'b0;
      sda_oe <= 1'b0;
      pmask <= '0;
    end else if (!live) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      ack_drv <= 1'b0;
      if (commit) begin
        pmask <= '0;
      end
    end else if (start_c) begin
      state <= ST_SLAVE;
      bitcnt <= '0;
      sda_oe <= 1'b0;
      ack_drv <= 1'b0;
    end else if (stop_c) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      ack_drv <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        ST_SLAVE, ST_WORD, ST_WDATA: begin
          shreg <= rx_byte;
          bitcnt <= bitcnt + 1'b1;
          if (bitcnt == 3'h7) begin
            if (state == ST_SLAVE) begin
              // both select pins compared; slave byte bit 1 is the upper address bit
              if (rx_byte[7:4] == DEV_TYPE && rx_byte[3:2] == sel_s) begin
                state <= ST_SACK;
                rw <= rx_byte[0];
                addr[8] <= rx_byte[1];
              end else begin
                state <= ST_IDLE;
              end
            end else if (state == ST_WORD) begin
              addr[7:0] <= rx_byte;
              state <= ST_WACK;
            end else begin
              pbuf[addr[3:0]] <= rx_byte;
              pmask[addr[3:0]] <= 1'b1;
              page <= addr[8:4];
              addr[3:0] <= addr[3:0] + 4'h1;
              state <= ST_DACK;
            end
          end
        end
        ST_RACK: begin
          if (sda) begin
            state <= ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_SACK, ST_WACK, ST_DACK: begin
          if (!ack_drv) begin
            sda_oe <= 1'b1;
            ack_drv <= 1'b1;
          end else begin
            ack_drv <= 1'b0;
            bitcnt <= '0;
            if (state == ST_SACK && rw) begin
              sda_oe <= ~rd_byte[7];
              shreg <= {rd_byte[6:0], 1'b0};
              bitcnt <= 3'h1;
              addr <= addr + 9'h001;
              state <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= (state == ST_SACK) ? ST_WORD : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (bitcnt == 3'h0) begin
            sda_oe <= 1'b0;
            state <= ST_RACK;
          end else begin
            sda_oe <= ~shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 1'b1;
          end
        end
        ST_RACK: begin
          sda_oe <= ~rd_byte[7];
          shreg <= {rd_byte[6:0], 1'b0};
          bitcnt <= 3'h1;
          addr <= addr + 9'h001;
          state <= ST_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    sda_out <= 1'b0;
  end

  // ************************************
  // self-timed write cycle
  // ************************************
  assign wc_start = live & stop_c & (|pmask);
  assign commit = busy && wc_cnt == WCW'(WC_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy <= 1'b0;
      wc_cnt <= '0;
    end else if (busy) begin
      wc_cnt <= wc_cnt + 1'b1;
      if (commit) begin
        busy <= 1'b0;
      end
    end else if (wc_start) begin
      busy <= 1'b1;
      wc_cnt <= '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pmask[i]) begin
          mem[{page, 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // ************************************
  // apb registers
  // ************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      ctrl_en <= CTRL_EN_RESET;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= '0;
        pslverr <= 1'b0;
        if (paddr == ADDR_STATUS) begin
          prdata[STAT_BUSY_BIT] <= busy;
          prdata[STAT_READY_BIT] <= ready;
          prdata[STAT_STATE_LSB +: 4] <= 4'(state);
        end else if (paddr == ADDR_CTRL) begin
          prdata[CTRL_EN_BIT] <= ctrl_en;
        end else begin
          pslverr <= 1'b1;
        end
      end
      if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
        ctrl_en <= pwdata[CTRL_EN_BIT];
      end
    end
  end

  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_start;
    live && start_c;
  endsequence

  sequence s_stop_wr;
    live && stop_c && (|pmask);
  endsequence

  chk_slave_only_drive: assert property (
    sda_oe |-> state inside {ST_SACK, ST_WACK, ST_DACK, ST_RDATA})
    else $error("data line driven outside ack or read");
  chk_rx_shift_edge: assert property (
    live && !start_c && !stop_c && scl_rise && state == ST_WORD |=> shreg[0] == $past(sda))
    else $error("received bit not shifted on clock rise");
  chk_drive_low_only: assert property (
    sda_oe |-> !sda_out)
    else $error("data line driven high");
  chk_sel_addr_match: assert property (
    state == ST_SACK && $past(state) == ST_SLAVE |-> $past(rx_byte[3:2]) == $past(sel_s))
    else $error("acked with wrong select bits");
  chk_wc_hold_busy: assert property (
    busy && !commit |=> busy)
    else $error("write cycle ended early");
  chk_busy_quiet_bus: assert property (
    busy |-> !sda_oe && state == ST_IDLE)
    else $error("bus active during write cycle");
  chk_glitch_filter: assert property (
    $changed(scl) |-> $past(g_filt[LN_SCL].cnt) == FW'(FILT_CYC - 1))
    else $error("clock changed before filter time");
  chk_start_seen: assert property (
    s_start |=> state == ST_SLAVE && bitcnt == 3'h0)
    else $error("start not taken");
  chk_half_select: assert property (
    state == ST_SACK && $past(state) == ST_SLAVE |-> addr[8] == $past(rx_byte[1]))
    else $error("half select not taken from slave byte");
  chk_page_wrap: assert property (
    state == ST_DACK && $past(state) == ST_WDATA |->
      addr[8:4] == $past(addr[8:4]) && addr[3:0] == $past(addr[3:0]) + 4'h1)
    else $error("page address not wrapped in low bits");
  chk_wc_start_stop: assert property (
    s_stop_wr |=> busy ##1 busy)
    else $error("write cycle not started at stop");

endmodule : setw_slave

`default_nettype wire
